// file: apbp_fifo.sv
// Shared constants of the ADC parallel host port, and its small result buffer.
// Assumes one clock and an asynchronous active-low reset; both sides of the
// buffer sit in that same clock domain.

`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------------------------------------------
// Package
// ----------------------------------------------------------------------------
package apbp_pkg;
    localparam int CLK_PERIOD_NS = 10; // System clock period
    localparam int INT_CLK_PERIOD_NS = 50; // Internal conversion clock, 20 MHz
    localparam int INT_DIV = (INT_CLK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS; // Cycles per tick
    localparam int NUM_CH = 8; // Analog channels
    localparam int RES_W = 12; // Result width, full bus
    localparam int CFG_W = 8; // Configuration width, lines 0 to 7
    localparam int TICKS_PER_CONV = 4; // Conversion clock ticks per channel
    localparam int BUF_DEPTH = 2; // Result buffer entries
    localparam logic [7:0] CFG_RESET = 8'hFF; // All channels enabled
    localparam logic [7:0] DIV_ZERO = 8'h00; // Divider restart value
    localparam logic [7:0] CNT_ZERO = 8'h00; // Tick counter restart value

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001, // Waiting for sample start
        ST_CONV = 3'b010, // Converting one channel
        ST_PUSH = 3'b100 // Handing a result to the buffer
    } apbp_state_t;
endpackage : apbp_pkg

// ----------------------------------------------------------------------------
// Result buffer
// ----------------------------------------------------------------------------
module apbp_fifo #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 2
) (
    input wire logic clock, // System clock
    input wire logic reset_n, // Asynchronous reset, active low
    input wire logic in_valid, // Word offered
    output logic in_ready, // Room for a word
    input wire logic [WIDTH-1:0] in_data, // Word in
    output logic out_valid, // Word at head
    input wire logic out_ready, // Head taken
    output logic [WIDTH-1:0] out_data // Head word
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1; // Pointer width
    localparam int CW = $clog2(DEPTH + 1); // Count width

    logic [WIDTH-1:0] mem_q [DEPTH]; // Storage flip-flops
    logic [WIDTH-1:0] mem_d [DEPTH]; // Next storage
    logic [PW-1:0] wr_q, wr_d; // Write index
    logic [PW-1:0] rd_q, rd_d; // Read index
    logic [CW-1:0] cnt_q, cnt_d; // Fill level
    logic push, pop; // Handshakes

    assign in_ready = (cnt_q != CW'(DEPTH)); // Honest full
    assign out_valid = (cnt_q != '0); // Honest empty
    assign out_data = mem_q[rd_q]; // Head shown
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // Next state of pointers, level and storage
    always_comb begin
        mem_d = mem_q;
        wr_d = wr_q;
        rd_d = rd_q;
        cnt_d = cnt_q;
        if (push) begin
            mem_d[wr_q] = in_data;
            wr_d = (wr_q == PW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
        end
        if (pop) begin
            rd_d = (rd_q == PW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
        end
        if (push && !pop) begin
            cnt_d = cnt_q + 1'b1;
        end else if (pop && !push) begin
            cnt_d = cnt_q - 1'b1;
        end
    end

    // Registers only
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_q[i] <= '0;
            end
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            mem_q <= mem_d;
            wr_q <= wr_d;
            rd_q <= rd_d;
            cnt_q <= cnt_d;
        end
    end
endmodule : apbp_fifo

`default_nettype wire

// file: apbp_port.sv
// Parallel host port of a multichannel simultaneous-sampling converter.
// Assumes all pins are synchronous to clock; the bus wire itself is resolved
// outside from data_out and data_oe_n.

`timescale 1ns/10ps
`default_nettype none

module apbp_port #(
    parameter int NUM_CH = apbp_pkg::NUM_CH,
    parameter int TICKS_PER_CONV = apbp_pkg::TICKS_PER_CONV,
    parameter int BUF_DEPTH = apbp_pkg::BUF_DEPTH
) (
    input wire logic clock, // System clock, 100 MHz
    input wire logic reset_n, // Asynchronous reset, active low
    input wire logic cs_n, // Chip select, active low
    input wire logic rd_n, // Read strobe, active low
    input wire logic wr_n, // Write strobe, active low
    input wire logic sample_start, // Rise samples, fall ends flags
    input wire logic ext_conv_clk, // External conversion clock
    input wire logic clock_source_select, // High selects internal clock
    input wire logic [NUM_CH*apbp_pkg::RES_W-1:0] sample_data, // Digitised channel inputs
    input wire logic [apbp_pkg::CFG_W-1:0] data_in, // Bus lines 0 to 7, input
    output logic [apbp_pkg::RES_W-1:0] data_out, // Bus lines, output value
    output logic [apbp_pkg::RES_W-1:0] data_oe_n, // Bus drive, low drives
    output logic eoc_n, // Per-conversion done, active low
    output logic sequence_done_n // Sequence done, active low
);
    localparam int RW = apbp_pkg::RES_W;
    localparam int CH_W = (NUM_CH > 1) ? $clog2(NUM_CH) : 1;

    // ------------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------------
    apbp_pkg::apbp_state_t st_q, st_d; // Sequencer state
    logic [7:0] div_q, div_d; // Internal clock divider
    logic [7:0] cnt_q, cnt_d; // Ticks within a conversion
    logic [CH_W-1:0] ch_q, ch_d; // Channel being converted
    logic [NUM_CH*RW-1:0] hold_q, hold_d; // Held samples
    logic [apbp_pkg::CFG_W-1:0] cfg_q, cfg_d; // Channel mask, write only
    logic ss_q, clk_q, rd_q, wr_q; // Previous pin levels
    logic eoc_d, seq_d; // Flag next values
    logic [RW-1:0] dout_d, oe_d; // Bus next values
    logic [CH_W-1:0] last_ch_q, last_ch_d; // Last pushed channel
    logic any_q, any_d; // Something pushed this sequence

    // Edges and strobes
    logic tick, ss_rise, ss_fall, wr_end, rd_end;
    logic more, push, finish;
    logic buf_ready, buf_valid;
    logic [RW-1:0] buf_data, res_word;

    // ------------------------------------------------------------------------
    // Edge detection
    // ------------------------------------------------------------------------
    // Pins count as synchronous, so a single stage of history is enough
    assign ss_rise = sample_start && !ss_q;
    assign ss_fall = !sample_start && ss_q;
    assign tick = clock_source_select ? (div_q == 8'(apbp_pkg::INT_DIV - 1)) : (ext_conv_clk && !clk_q);
    assign wr_end = wr_n && !wr_q && !cs_n;
    assign rd_end = rd_n && !rd_q && !cs_n;
    assign res_word = hold_q[ch_q*RW +: RW];

    // Any enabled channel above the current one
    always_comb begin
        more = 1'b0;
        for (int i = 0; i < NUM_CH; i++) begin
            if (i > int'(ch_q) && cfg_q[i]) begin
                more = 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------------
    // A full buffer holds the sequencer in PUSH, so no result is overwritten
    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        ch_d = ch_q;
        hold_d = hold_q;
        push = 1'b0;
        finish = 1'b0;
        div_d = tick || !clock_source_select ? apbp_pkg::DIV_ZERO : div_q + 8'h01;
        case (st_q)
            apbp_pkg::ST_IDLE: begin
                // New start ignored while a sequence runs
                if (ss_rise) begin
                    hold_d = sample_data;
                    ch_d = '0;
                    cnt_d = apbp_pkg::CNT_ZERO;
                    st_d = apbp_pkg::ST_CONV;
                end
            end
            apbp_pkg::ST_CONV: begin
                if (!cfg_q[ch_q]) begin
                    // Masked channel skipped without conversion time
                    if (more) begin
                        ch_d = ch_q + 1'b1;
                    end else begin
                        finish = 1'b1;
                        st_d = apbp_pkg::ST_IDLE;
                    end
                end else if (tick) begin
                    cnt_d = cnt_q + 8'h01;
                    if (cnt_q == 8'(TICKS_PER_CONV - 1)) begin
                        st_d = apbp_pkg::ST_PUSH;
                    end
                end
            end
            apbp_pkg::ST_PUSH: begin
                if (buf_ready) begin
                    push = 1'b1;
                    cnt_d = apbp_pkg::CNT_ZERO;
                    if (more) begin
                        ch_d = ch_q + 1'b1;
                        st_d = apbp_pkg::ST_CONV;
                    end else begin
                        finish = 1'b1;
                        st_d = apbp_pkg::ST_IDLE;
                    end
                end
            end
            default: begin
                st_d = apbp_pkg::ST_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------------------
    // Flags, configuration and bus
    // ------------------------------------------------------------------------
    // A set in the same cycle as a release always wins
    always_comb begin
        eoc_d = eoc_n;
        seq_d = sequence_done_n;
        if (push) begin
            eoc_d = 1'b0;
        end else if (tick || ss_fall) begin
            eoc_d = 1'b1;
        end
        if (finish) begin
            seq_d = 1'b0;
        end else if (ss_fall) begin
            seq_d = 1'b1;
        end
        // Only lines 0 to 7 are ever sampled from the bus
        cfg_d = wr_end ? data_in : cfg_q;
        dout_d = buf_data;
        // Drive lags the strobes by one cycle
        oe_d[apbp_pkg::CFG_W-1:0] = {apbp_pkg::CFG_W{cs_n || rd_n}};
        // Upper lines have no input path, only this drive
        oe_d[RW-1:apbp_pkg::CFG_W] = {(RW - apbp_pkg::CFG_W){cs_n || rd_n}};
        last_ch_d = push ? ch_q : last_ch_q;
        any_d = (st_q == apbp_pkg::ST_IDLE && ss_rise) ? 1'b0 : (any_q || push);
    end

    // Registers only
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            st_q <= apbp_pkg::ST_IDLE;
            div_q <= apbp_pkg::DIV_ZERO;
            cnt_q <= apbp_pkg::CNT_ZERO;
            ch_q <= '0;
            hold_q <= '0;
            cfg_q <= apbp_pkg::CFG_RESET;
            ss_q <= 1'b0;
            clk_q <= 1'b0;
            rd_q <= 1'b1;
            wr_q <= 1'b1;
            eoc_n <= 1'b1;
            sequence_done_n <= 1'b1;
            data_out <= '0;
            data_oe_n <= '1;
            last_ch_q <= '0;
            any_q <= 1'b0;
        end else begin
            st_q <= st_d;
            div_q <= div_d;
            cnt_q <= cnt_d;
            ch_q <= ch_d;
            hold_q <= hold_d;
            cfg_q <= cfg_d;
            ss_q <= sample_start;
            clk_q <= ext_conv_clk;
            rd_q <= rd_n;
            wr_q <= wr_n;
            eoc_n <= eoc_d;
            sequence_done_n <= seq_d;
            data_out <= dout_d;
            data_oe_n <= oe_d;
            last_ch_q <= last_ch_d;
            any_q <= any_d;
        end
    end

    // ------------------------------------------------------------------------
    // Result buffer
    // ------------------------------------------------------------------------
    // Each read strobe with cs_n low, at its rising end, retires the head result, if the buffer holds one
    apbp_fifo #(
        .WIDTH(RW),
        .DEPTH(BUF_DEPTH)
    ) u_buf (
        .clock(clock),
        .reset_n(reset_n),
        .in_valid(push),
        .in_ready(buf_ready),
        .in_data(res_word),
        .out_valid(buf_valid),
        .out_ready(rd_end),
        .out_data(buf_data)
    );

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    AST_FLOAT: assert property (@(posedge clock) disable iff (!reset_n)
        (cs_n || rd_n) |=> (data_oe_n == {RW{1'b1}}))
        else $error("bus driven while not reading");
    AST_DRIVE: assert property (@(posedge clock) disable iff (!reset_n)
        (!cs_n && !rd_n) |=> (data_oe_n == '0) && (data_out == $past(buf_data)))
        else $error("read did not drive result");
    AST_UPPER: assert property (@(posedge clock) disable iff (!reset_n)
        data_oe_n[RW-1:apbp_pkg::CFG_W] == {(RW - apbp_pkg::CFG_W){data_oe_n[0]}})
        else $error("upper lines not plain outputs");
    AST_EOC_LOW: assert property (@(posedge clock) disable iff (!reset_n)
        push |=> !eoc_n)
        else $error("done flag missing after conversion");
    AST_EOC_HIGH: assert property (@(posedge clock) disable iff (!reset_n)
        (!eoc_n && (tick || ss_fall) && !push) |=> eoc_n)
        else $error("done flag not released");
    AST_SEQ_LOW: assert property (@(posedge clock) disable iff (!reset_n)
        finish |=> !sequence_done_n && (st_q == apbp_pkg::ST_IDLE))
        else $error("sequence flag missing");
    AST_SEQ_HOLD: assert property (@(posedge clock) disable iff (!reset_n)
        (!sequence_done_n && !sample_start && !$past(sample_start)) |=> !sequence_done_n)
        else $error("sequence flag released early");
    AST_CFG: assert property (@(posedge clock) disable iff (!reset_n)
        (wr_n && !$past(wr_n) && !cs_n) |=> (cfg_q == $past(data_in)))
        else $error("configuration not captured");
    AST_CS: assert property (@(posedge clock) disable iff (!reset_n)
        cs_n |=> $stable(cfg_q))
        else $error("write taken while deselected");
    AST_SAMPLE: assert property (@(posedge clock) disable iff (!reset_n)
        (st_q == apbp_pkg::ST_IDLE && ss_rise) |=> (hold_q == $past(sample_data)) ##0 (st_q == apbp_pkg::ST_CONV))
        else $error("samples not held at start");
    AST_MASK: assert property (@(posedge clock) disable iff (!reset_n)
        push |-> cfg_q[ch_q])
        else $error("masked channel converted");
    AST_ORDER: assert property (@(posedge clock) disable iff (!reset_n)
        (push && any_q) |-> (ch_q > last_ch_q))
        else $error("channels out of order");
endmodule : apbp_port

`default_nettype wire

// file: apbp_host.sv
// Host bus controller model facing the parallel port of the converter.
// Assumes one system clock; strobes change on its falling edge only.
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------------------------------------------
// Host model
// ----------------------------------------------------------------------------
module apbp_host (
    input wire logic clock, // System clock
    input wire logic clock_source_select, // High selects internal tick
    input wire logic [11:0] data_out, // Device bus value
    input wire logic [11:0] data_oe_n, // Device drive, low drives
    output logic cs_n = 1'b1, // Chip select, active low
    output logic rd_n = 1'b1, // Read strobe, active low
    output logic wr_n = 1'b1, // Write strobe, active low
    output logic ext_conv_clk = 1'b0, // Conversion clock from host
    output logic [7:0] data_in, // Lines 0 to 7 as device sees them
    output logic [11:0] bus // Resolved bus wire
);
    logic host_oe = 1'b0; // Host drives lines 0 to 7
    logic [7:0] host_val = 8'h00; // Value host drives
    int ph = 0; // External clock phase count

    // Wire level; a floating line shows the inverse so stale data never matches
    always_comb begin
        for (int i = 0; i < 12; i++) begin
            if (!data_oe_n[i]) begin
                bus[i] = data_out[i];
            end else if (i < 8 && host_oe) begin
                bus[i] = host_val[i % 8];
            end else begin
                bus[i] = ~data_out[i];
            end
        end
    end
    assign data_in = bus[7:0];

    // Period of six system clocks, inside the allowed band; tied low when internal
    always @(negedge clock) begin
        if (clock_source_select) begin
            ext_conv_clk <= 1'b0;
        end else if (ph == 2) begin
            ext_conv_clk <= ~ext_conv_clk;
            ph <= 0;
        end else begin
            ph <= ph + 1;
        end
    end

    // Configuration write; data held until the edge that sees the strobe rise
    task automatic write_cfg(input logic [7:0] m, input logic sel);
        @(negedge clock);
        cs_n = ~sel;
        wr_n = 1'b0;
        host_oe = 1'b1;
        host_val = m;
        @(negedge clock);
        wr_n = 1'b1;
        @(negedge clock);
        cs_n = 1'b1;
        host_oe = 1'b0;
    endtask : write_cfg

    // One read pulse; bus sampled while the strobe is low
    task automatic read_word(output logic [11:0] w, output logic [11:0] drv, output logic [11:0] rel,
                             input logic sel);
        @(negedge clock);
        cs_n = ~sel;
        rd_n = 1'b0;
        @(negedge clock);
        w = bus;
        drv = data_oe_n;
        rd_n = 1'b1;
        @(negedge clock);
        rel = data_oe_n;
        cs_n = 1'b1;
    endtask : read_word
endmodule : apbp_host
`default_nettype wire

// file: apbp_port_tb.sv
// Self-checking bench of the parallel host port.
// Assumes the host model drives the bus; the bench drives start and samples.
`timescale 1ns/10ps
`default_nettype none

module apbp_port_tb;
    logic clock = 1'b0; // System clock
    logic reset_n = 1'b0; // Reset, active low
    logic sample_start = 1'b0; // Conversion start
    logic clock_source_select = 1'b1; // Internal tick first
    logic [95:0] sample_data; // Channel values
    logic cs_n, rd_n, wr_n, ext_conv_clk, eoc_n, sequence_done_n;
    logic [7:0] data_in; // Lines 0 to 7 into device
    logic [11:0] data_out, data_oe_n, bus, w, drv, rel;
    int n_mismatch = 0; // Mismatch count
    int checks = 0; // Comparison count
    int k; // Bounded wait count

    apbp_port #(.NUM_CH(8), .TICKS_PER_CONV(4), .BUF_DEPTH(2)) i_apbp_port (
        .clock(clock), .reset_n(reset_n), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
        .sample_start(sample_start), .ext_conv_clk(ext_conv_clk),
        .clock_source_select(clock_source_select), .sample_data(sample_data), .data_in(data_in),
        .data_out(data_out), .data_oe_n(data_oe_n), .eoc_n(eoc_n), .sequence_done_n(sequence_done_n));

    apbp_host i_apbp_host (
        .clock(clock), .clock_source_select(clock_source_select), .data_out(data_out),
        .data_oe_n(data_oe_n), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .ext_conv_clk(ext_conv_clk),
        .data_in(data_in), .bus(bus));

    // Distinct value per channel, upper nibble too
    function automatic logic [11:0] chv(input int i);
        return 12'(12'h111 * i + 12'h0A5);
    endfunction : chv

    task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic finish_test;
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : finish_test

    // Idle pins, deselected read, read on an empty buffer
    task automatic t_bus;
        chk("idle drive", 12'hFFF, data_oe_n);
        chk("idle flags", 12'h003, 12'({eoc_n, sequence_done_n}));
        i_apbp_host.read_word(w, drv, rel, 1'b0);
        chk("deselected drive", 12'hFFF, drv);
        i_apbp_host.read_word(w, drv, rel, 1'b1);
        chk("read drive", 12'h000, drv);
        chk("released drive", 12'hFFF, rel);
        $display("test bus done");
    endtask : t_bus

    // Mask of channels 0 and 2, flag timing, ordered results
    task automatic t_mask;
        i_apbp_host.write_cfg(8'h05, 1'b1);
        i_apbp_host.write_cfg(8'h01, 1'b0);
        @(negedge clock);
        sample_start = 1'b1;
        k = 0;
        while (eoc_n !== 1'b0 && k < 400) begin
            @(negedge clock);
            k++;
        end
        chk("done fall", 12'h000, 12'(eoc_n));
        k = 0;
        while (eoc_n === 1'b0 && k < 20) begin
            @(negedge clock);
            k++;
        end
        chk("done width", 12'h001, 12'(k <= 6));
        k = 0;
        while (sequence_done_n !== 1'b0 && k < 400) begin
            @(negedge clock);
            k++;
        end
        chk("sequence fall", 12'h000, 12'(sequence_done_n));
        repeat (10) @(negedge clock);
        chk("sequence held", 12'h000, 12'(sequence_done_n));
        sample_start = 1'b0;
        repeat (2) @(negedge clock);
        chk("sequence rise", 12'h001, 12'(sequence_done_n));
        i_apbp_host.read_word(w, drv, rel, 1'b1);
        chk("first result", chv(0), w);
        i_apbp_host.read_word(w, drv, rel, 1'b1);
        chk("second result", chv(2), w);
        $display("test mask done");
    endtask : t_mask

    // All channels on host clock; slow reads stall the buffer, nothing lost
    task automatic t_stall;
        i_apbp_host.write_cfg(8'hFF, 1'b1);
        clock_source_select = 1'b0;
        @(negedge clock);
        sample_start = 1'b1;
        for (int i = 0; i < 8; i++) begin
            repeat (120) @(negedge clock);
            i_apbp_host.read_word(w, drv, rel, 1'b1);
            chk("stalled result", chv(i), w);
        end
        chk("sequence end", 12'h000, 12'(sequence_done_n));
        sample_start = 1'b0;
        $display("test stall done");
    endtask : t_stall

    // Clock of 10 ns
    initial begin
        forever #5 clock = ~clock;
    end

    // Watchdog well above the expected run of about 1100 cycles
    initial begin
        repeat (20000) @(posedge clock);
        n_mismatch++;
        finish_test();
    end

    // Main sequence
    initial begin
        for (int i = 0; i < 8; i++) begin
            sample_data[i*12 +: 12] = chv(i);
        end
        repeat (5) @(negedge clock);
        reset_n = 1'b1;
        @(negedge clock);
        t_bus();
        t_mask();
        t_stall();
        finish_test();
    end
endmodule : apbp_port_tb
`default_nettype wire
